// ==== slt_host.sv ====
// Host end: issues one read command, clocks the latency, collects bytes.
// Assumes user requests on clk_i; the link lanes come back asynchronously.
`include "slt_params.svh"
`default_nettype none
module slt_host #(
	parameter int SCK_HALF = 16
) (
	input wire logic clk_i,
	input wire logic rst_i,
	slt_link_if.host lnk,
	input wire logic start_i,
	input wire logic [7:0] opcode_i,
	input wire logic [31:0] addr_i,
	input wire logic [7:0] nbytes_i,
	input wire logic [1:0] latency_code_i,
	output logic busy_o,
	output logic [7:0] rdata_o,
	output logic rvalid_o,
	output logic done_o,
	output logic refused_o,
	output logic [31:0] next_param_o
);
	localparam int SCK_MHZ = `SLT_CLK_MHZ / (2*SCK_HALF);
	if (SCK_HALF < `SLT_MIN_HALF) begin : g_chk
		$error("slt_host: SCK_HALF too small for the device synchroniser");
	end

	logic [15:0] div_r;
	logic sck_r;
	logic tick;
	logic rise_tick;
	logic fall_tick;
	logic [3:0] sync1_r;
	logic [3:0] sync2_r;
	slt_pkg::slt_phase_t ph_r;
	slt_pkg::slt_phase_t ph_adv;
	logic [7:0] ccnt_r;
	logic [7:0] ccnt_adv;
	logic [39:0] tx_r;
	logic [39:0] tx_adv;
	logic [7:0] alen_r;
	logic [2:0] alanes_r;
	logic [2:0] dlanes_r;
	logic [7:0] mode_r;
	logic [7:0] dummy_r;
	logic [7:0] nleft_r;
	logic [7:0] bidx_r;
	logic [7:0] rx_r;
	logic [7:0] rx_w;
	logic [2:0] rcnt_r;
	logic [31:0] base_r;
	logic cs_n_r;
	logic [3:0] io_o_r;
	logic [3:0] oe_n_r;
	logic busy_r;
	logic [7:0] rdata_r;
	logic rvalid_r;
	logic done_r;
	logic refused_r;
	logic [31:0] next_r;

	// Request check against the row chosen for this clock rate
	slt_pkg::slt_fam_t fam_w;
	logic [7:0] mode_w;
	logic [7:0] dummy_w;
	logic bad_w;
	always_comb begin
		fam_w = slt_pkg::slt_fam_of(opcode_i);
		mode_w = slt_pkg::slt_mode_of(fam_w, slt_pkg::slt_row_of(latency_code_i, SCK_MHZ));
		dummy_w = slt_pkg::slt_dummy_of(fam_w, slt_pkg::slt_row_of(latency_code_i, SCK_MHZ));
		bad_w = (fam_w == slt_pkg::SLT_FAM_NONE) || (mode_w == `SLT_NOSUP) ||
			(dummy_w == `SLT_NOSUP) || (nbytes_i == 8'h00) ||
			(SCK_MHZ > int'(slt_pkg::slt_ceil_of(slt_pkg::slt_row_of(latency_code_i, SCK_MHZ))));
	end

	// SCK divider runs only while a command is open
	always_ff @(posedge clk_i or posedge rst_i) begin
		if (rst_i) begin
			div_r <= 16'h0000;
			sck_r <= 1'b0;
		end else if (ph_r == slt_pkg::SLT_PH_IDLE) begin
			div_r <= 16'h0000;
			sck_r <= 1'b0;
		end else if (tick) begin
			div_r <= 16'h0000;
			sck_r <= (ph_r == slt_pkg::SLT_PH_DONE) ? 1'b0 : ~sck_r;
		end else begin
			div_r <= div_r + 16'h0001;
		end
	end

	assign tick = (div_r == 16'(SCK_HALF - 1));
	assign rise_tick = tick & ~sck_r & (ph_r != slt_pkg::SLT_PH_DONE);
	assign fall_tick = tick & sck_r;

	// Lanes back from the device pass two flops
	always_ff @(posedge clk_i or posedge rst_i) begin
		if (rst_i) begin
			sync1_r <= 4'hF;
			sync2_r <= 4'hF;
		end else begin
			sync1_r <= lnk.io;
			sync2_r <= sync1_r;
		end
	end

	// Phase advance at each falling edge, skipping empty phases
	always_comb begin
		ph_adv = ph_r;
		ccnt_adv = ccnt_r + 8'h01;
		tx_adv = 40'(tx_r << ((ph_r == slt_pkg::SLT_PH_OPC) ? `SLT_LANES1 : alanes_r));
		case (ph_r)
			slt_pkg::SLT_PH_OPC: begin
				if (ccnt_adv == `SLT_OP_BITS) begin
					ph_adv = slt_pkg::SLT_PH_ADDR;
					ccnt_adv = 8'h00;
				end
			end
			slt_pkg::SLT_PH_ADDR: begin
				if (8'(ccnt_adv * alanes_r) == alen_r) begin
					ph_adv = slt_pkg::slt_after_addr(mode_r, dummy_r);
					ccnt_adv = 8'h00;
				end
			end
			slt_pkg::SLT_PH_MODE: begin
				if (ccnt_adv == mode_r) begin
					ph_adv = (dummy_r != 8'h00) ? slt_pkg::SLT_PH_DUMMY : slt_pkg::SLT_PH_DATA;
					ccnt_adv = 8'h00;
				end
			end
			slt_pkg::SLT_PH_DUMMY: begin
				if (ccnt_adv == dummy_r) begin
					ph_adv = slt_pkg::SLT_PH_DATA;
					ccnt_adv = 8'h00;
				end
			end
			default: begin
				ccnt_adv = ccnt_r;
			end
		endcase
		if (dlanes_r == `SLT_LANES4) begin
			rx_w = {rx_r[3:0], sync2_r};
		end else if (dlanes_r == `SLT_LANES2) begin
			rx_w = {rx_r[5:0], sync2_r[1:0]};
		end else begin
			rx_w = {rx_r[6:0], sync2_r[1]};
		end
	end

	// Command sequencer; lanes drive on falls, samples taken on rises
	always_ff @(posedge clk_i or posedge rst_i) begin
		if (rst_i) begin
			ph_r <= slt_pkg::SLT_PH_IDLE;
			ccnt_r <= 8'h00;
			tx_r <= 40'h00_0000_0000;
			alen_r <= `SLT_A3_BITS;
			alanes_r <= `SLT_LANES1;
			dlanes_r <= `SLT_LANES1;
			mode_r <= 8'h00;
			dummy_r <= 8'h00;
			nleft_r <= 8'h00;
			bidx_r <= 8'h00;
			rx_r <= 8'h00;
			rcnt_r <= 3'h0;
			base_r <= 32'h0000_0000;
			cs_n_r <= 1'b1;
			io_o_r <= 4'h0;
			oe_n_r <= `SLT_OE_OFF;
			busy_r <= 1'b0;
			rdata_r <= 8'h00;
			rvalid_r <= 1'b0;
			done_r <= 1'b0;
			refused_r <= 1'b0;
			next_r <= 32'h0000_0000;
		end else begin
			rvalid_r <= 1'b0;
			done_r <= 1'b0;
			refused_r <= 1'b0;
			if (ph_r == slt_pkg::SLT_PH_IDLE) begin
				if (start_i && bad_w) begin
					refused_r <= 1'b1;
				end else if (start_i) begin
					ph_r <= slt_pkg::SLT_PH_OPC;
					ccnt_r <= 8'h00;
					tx_r <= slt_pkg::slt_is_a4(opcode_i) ? {opcode_i, addr_i} :
						{opcode_i, addr_i[23:0], 8'h00};
					alen_r <= slt_pkg::slt_is_a4(opcode_i) ? `SLT_A4_BITS : `SLT_A3_BITS;
					alanes_r <= slt_pkg::slt_addr_lanes(fam_w);
					dlanes_r <= slt_pkg::slt_data_lanes(fam_w);
					mode_r <= mode_w;
					dummy_r <= dummy_w;
					nleft_r <= nbytes_i;
					bidx_r <= 8'h00;
					rcnt_r <= 3'h0;
					base_r <= addr_i;
					cs_n_r <= 1'b0;
					io_o_r <= {3'h0, opcode_i[7]};
					oe_n_r <= `SLT_OE_X1_IN;
					busy_r <= 1'b1;
				end
			end else if (ph_r == slt_pkg::SLT_PH_DONE) begin
				if (tick && !cs_n_r) begin
					cs_n_r <= 1'b1;
				end else if (tick) begin
					ph_r <= slt_pkg::SLT_PH_IDLE;
					busy_r <= 1'b0;
					done_r <= 1'b1;
				end
			end else if (rise_tick && ph_r == slt_pkg::SLT_PH_DATA) begin
				rx_r <= rx_w;
				rcnt_r <= 3'(rcnt_r + dlanes_r);
				if (3'(rcnt_r + dlanes_r) == 3'h0) begin
					rdata_r <= rx_w;
					rvalid_r <= 1'b1;
					bidx_r <= bidx_r + 8'h01;
					nleft_r <= nleft_r - 8'h01;
					if (32'(bidx_r) == `SLT_OFS_LEN) begin
						next_r <= base_r + `SLT_OFS_LEN + 32'(rx_w) + 32'h0000_0001;
					end
					if (nleft_r == 8'h01) begin
						ph_r <= slt_pkg::SLT_PH_DONE;
					end
				end
			end else if (fall_tick && ph_r != slt_pkg::SLT_PH_DATA) begin
				ph_r <= ph_adv;
				ccnt_r <= ccnt_adv;
				tx_r <= tx_adv;
				// Lanes released for dummies so the device can turn them round
				if (ph_adv == slt_pkg::SLT_PH_OPC) begin
					io_o_r <= {3'h0, tx_adv[39]};
					oe_n_r <= `SLT_OE_X1_IN;
				end else if (ph_adv == slt_pkg::SLT_PH_ADDR || ph_adv == slt_pkg::SLT_PH_MODE) begin
					if (alanes_r == `SLT_LANES4) begin
						io_o_r <= tx_adv[39:36];
						oe_n_r <= `SLT_OE_X4;
					end else if (alanes_r == `SLT_LANES2) begin
						io_o_r <= {2'h0, tx_adv[39:38]};
						oe_n_r <= `SLT_OE_X2;
					end else begin
						io_o_r <= {3'h0, tx_adv[39]};
						oe_n_r <= `SLT_OE_X1_IN;
					end
				end else begin
					oe_n_r <= `SLT_OE_OFF;
				end
			end
		end
	end

	assign lnk.sck = sck_r;
	assign lnk.cs_n = cs_n_r;
	assign lnk.h_io_o = io_o_r;
	assign lnk.h_io_oe_n = oe_n_r;
	assign busy_o = busy_r;
	assign rdata_o = rdata_r;
	assign rvalid_o = rvalid_r;
	assign done_o = done_r;
	assign refused_o = refused_r;
	assign next_param_o = next_r;
endmodule
`default_nettype wire

// ==== slt_params.svh ====
// Constants of the read-latency link: opcodes, table bytes, lane codes.
// Assumes inclusion by the package and by both link ends.
`ifndef SLT_PARAMS_SVH
`define SLT_PARAMS_SVH
// Read opcodes, 3-byte and 4-byte address forms
`define SLT_OP_READ3 8'h03
`define SLT_OP_READ4 8'h13
`define SLT_OP_FAST3 8'h0B
`define SLT_OP_FAST4 8'h0C
`define SLT_OP_DOUT3 8'h3B
`define SLT_OP_DOUT4 8'h3C
`define SLT_OP_QOUT3 8'h6B
`define SLT_OP_QOUT4 8'h6C
`define SLT_OP_DIO3 8'hBB
`define SLT_OP_DIO4 8'hBC
`define SLT_OP_QIO3 8'hEB
`define SLT_OP_QIO4 8'hEC
// Parameter header
`define SLT_PARAM_ID 8'h90
`define SLT_PARAM_LEN 8'h56
`define SLT_NUM_ROWS 8'h06
`define SLT_ROW_BYTES 8'h0E
`define SLT_OFS_ID 32'h0000_0000
`define SLT_OFS_LEN 32'h0000_0001
`define SLT_OFS_ROWS 32'h0000_0002
`define SLT_OFS_ROWLEN 32'h0000_0003
`define SLT_OFS_TBL 32'h0000_0004
`define SLT_PARAM_END 32'h0000_0058
// Table rows: frequency, code, then mode/dummy pairs per family
`define SLT_ROW_LEN 14
`define SLT_CYC_OFS 2
`define SLT_CYC_PAIR 2
`define SLT_TBL_BITS 672
`define SLT_HDR 112'h4643_0313_0B0C_3B3C_6B6C_BBBC_EBEC
`define SLT_ROW2 112'h3203_0000_0000_0000_0000_0004_0201
`define SLT_ROW3 112'h5000_FFFF_0008_0008_0008_0004_0204
`define SLT_ROW4 112'h5A01_FFFF_0008_0008_0008_0005_0204
`define SLT_ROW5 112'h6802_FFFF_0008_0008_0008_0006_0205
`define SLT_ROW6 112'h8502_FFFF_0008_FFFF_FFFF_FFFF_FFFF
`define SLT_NOSUP 8'hFF
// Latency codes and their rows
`define SLT_LC_50 2'h3
`define SLT_LC_80 2'h0
`define SLT_LC_90 2'h1
`define SLT_LC_104 2'h2
`define SLT_ROW_IDX_50 1
`define SLT_ROW_IDX_80 2
`define SLT_ROW_IDX_90 3
`define SLT_ROW_IDX_104 4
`define SLT_ROW_IDX_133 5
// Bit counts and lanes
`define SLT_OP_BITS 8'h08
`define SLT_A3_BITS 8'h18
`define SLT_A4_BITS 8'h20
`define SLT_LANES1 3'h1
`define SLT_LANES2 3'h2
`define SLT_LANES4 3'h4
`define SLT_OE_X1_IN 4'hE
`define SLT_OE_X1_OUT 4'hD
`define SLT_OE_X2 4'hC
`define SLT_OE_X4 4'h0
`define SLT_OE_OFF 4'hF
`define SLT_SYNC_RST 6'h1F
`define SLT_CLK_MHZ 250
`define SLT_DEV_MHZ 104
// Data turnaround passes both synchronisers, so a half period needs six clocks
`define SLT_MIN_HALF 6
`endif

// ==== slt_pkg.sv ====
// Types and table lookups shared by both ends of the read link.
// Assumes slt_params.svh is on the include path.
`include "slt_params.svh"
`default_nettype none
package slt_pkg;
	typedef enum logic [2:0] {
		SLT_FAM_READ = 3'b000,
		SLT_FAM_FAST = 3'b001,
		SLT_FAM_DOUT = 3'b010,
		SLT_FAM_QOUT = 3'b011,
		SLT_FAM_DIO = 3'b100,
		SLT_FAM_QIO = 3'b101,
		SLT_FAM_NONE = 3'b111
	} slt_fam_t;
	typedef enum logic [2:0] {
		SLT_PH_IDLE = 3'b000,
		SLT_PH_OPC = 3'b001,
		SLT_PH_ADDR = 3'b010,
		SLT_PH_MODE = 3'b011,
		SLT_PH_DUMMY = 3'b100,
		SLT_PH_DATA = 3'b101,
		SLT_PH_DONE = 3'b110,
		SLT_PH_IGN = 3'b111
	} slt_phase_t;
	localparam logic [`SLT_TBL_BITS-1:0] SLT_TABLE =
		{`SLT_HDR, `SLT_ROW2, `SLT_ROW3, `SLT_ROW4, `SLT_ROW5, `SLT_ROW6};
	// Byte idx of the table, header row first
	function automatic logic [7:0] slt_tbl_byte(input int idx);
		return SLT_TABLE[`SLT_TBL_BITS-1-8*idx -: 8];
	endfunction
	function automatic slt_fam_t slt_fam_of(input logic [7:0] op);
		case (op)
			`SLT_OP_READ3, `SLT_OP_READ4: return SLT_FAM_READ;
			`SLT_OP_FAST3, `SLT_OP_FAST4: return SLT_FAM_FAST;
			`SLT_OP_DOUT3, `SLT_OP_DOUT4: return SLT_FAM_DOUT;
			`SLT_OP_QOUT3, `SLT_OP_QOUT4: return SLT_FAM_QOUT;
			`SLT_OP_DIO3, `SLT_OP_DIO4: return SLT_FAM_DIO;
			`SLT_OP_QIO3, `SLT_OP_QIO4: return SLT_FAM_QIO;
			default: return SLT_FAM_NONE;
		endcase
	endfunction
	function automatic logic slt_is_a4(input logic [7:0] op);
		return op == `SLT_OP_READ4 || op == `SLT_OP_FAST4 || op == `SLT_OP_DOUT4 ||
			op == `SLT_OP_QOUT4 || op == `SLT_OP_DIO4 || op == `SLT_OP_QIO4;
	endfunction
	function automatic logic [2:0] slt_addr_lanes(input slt_fam_t f);
		return (f == SLT_FAM_DIO) ? `SLT_LANES2 : (f == SLT_FAM_QIO) ? `SLT_LANES4 : `SLT_LANES1;
	endfunction
	function automatic logic [2:0] slt_data_lanes(input slt_fam_t f);
		case (f)
			SLT_FAM_DOUT, SLT_FAM_DIO: return `SLT_LANES2;
			SLT_FAM_QOUT, SLT_FAM_QIO: return `SLT_LANES4;
			default: return `SLT_LANES1;
		endcase
	endfunction
	function automatic logic [7:0] slt_ceil_of(input int row);
		return slt_tbl_byte(`SLT_ROW_LEN*row);
	endfunction
	// Code 10b covers two rows; a clock rate above the 104 MHz row's ceiling picks the 133 MHz row
	function automatic int slt_row_of(input logic [1:0] code, input int mhz);
		case (code)
			`SLT_LC_50: return `SLT_ROW_IDX_50;
			`SLT_LC_80: return `SLT_ROW_IDX_80;
			`SLT_LC_90: return `SLT_ROW_IDX_90;
			default: return (mhz > int'(slt_ceil_of(`SLT_ROW_IDX_104))) ?
				`SLT_ROW_IDX_133 : `SLT_ROW_IDX_104;
		endcase
	endfunction
	function automatic logic [7:0] slt_mode_of(input slt_fam_t f, input int row);
		return slt_tbl_byte(`SLT_ROW_LEN*row + `SLT_CYC_OFS + `SLT_CYC_PAIR*int'(f));
	endfunction
	function automatic logic [7:0] slt_dummy_of(input slt_fam_t f, input int row);
		return slt_tbl_byte(`SLT_ROW_LEN*row + `SLT_CYC_OFS + `SLT_CYC_PAIR*int'(f) + 1);
	endfunction
	// Whole parameter as read from its relative offset
	function automatic logic [7:0] slt_param_byte(input logic [31:0] a);
		if (a == `SLT_OFS_ID) return `SLT_PARAM_ID;
		else if (a == `SLT_OFS_LEN) return `SLT_PARAM_LEN;
		else if (a == `SLT_OFS_ROWS) return `SLT_NUM_ROWS;
		else if (a == `SLT_OFS_ROWLEN) return `SLT_ROW_BYTES;
		else if (a < `SLT_PARAM_END) return slt_tbl_byte(int'(a - `SLT_OFS_TBL));
		else return `SLT_NOSUP;
	endfunction
	function automatic slt_phase_t slt_after_addr(input logic [7:0] m, input logic [7:0] d);
		return (m != 8'h00) ? SLT_PH_MODE : (d != 8'h00) ? SLT_PH_DUMMY : SLT_PH_DATA;
	endfunction
endpackage
`default_nettype wire

// ==== slt_link_if.sv ====
// Serial read link between host and device: clock, select, four lanes.
// Assumes each lane is pulled high when nobody drives it.
`default_nettype none
interface slt_link_if;
	logic sck;
	logic cs_n;
	logic [3:0] h_io_o;
	logic [3:0] h_io_oe_n;
	logic [3:0] d_io_o;
	logic [3:0] d_io_oe_n;
	logic [3:0] io;
	// Wire level: device first, then host, else pull-up
	assign io = (~d_io_oe_n & d_io_o) | (d_io_oe_n & ~h_io_oe_n & h_io_o) |
		(d_io_oe_n & h_io_oe_n);
	modport host (output sck, output cs_n, output h_io_o, output h_io_oe_n, input io);
	modport dev (input sck, input cs_n, input io, output d_io_o, output d_io_oe_n);
endinterface
`default_nettype wire

// ==== slt_dev.sv ====
// Device end: decodes read commands, applies the latency table, serves it.
// Assumes latency_code_i is static configuration on clk_i; link pins are async.
`include "slt_params.svh"
`default_nettype none
module slt_dev #(
	parameter int SCK_MHZ = `SLT_DEV_MHZ
) (
	input wire logic clk_i,
	input wire logic rst_i,
	slt_link_if.dev lnk,
	input wire logic [1:0] latency_code_i,
	output logic [7:0] cmd_o,
	output logic active_o,
	output logic refused_o
);
	if (SCK_MHZ < 1) begin : g_chk
		$error("slt_dev: SCK_MHZ must be positive");
	end

	logic [5:0] sync1_r;
	logic [5:0] sync2_r;
	logic sck_d_r;
	logic sck_rise;
	logic sck_fall;
	logic cs_n;
	logic [3:0] io_in;
	slt_pkg::slt_phase_t ph_r;
	slt_pkg::slt_fam_t fam_r;
	logic [7:0] cnt_r;
	logic [6:0] op_sh_r;
	logic [31:0] addr_r;
	logic [7:0] alen_r;
	logic [2:0] alanes_r;
	logic [2:0] dlanes_r;
	logic [7:0] mode_r;
	logic [7:0] dummy_r;
	logic [3:0] io_o_r;
	logic [3:0] io_oe_n_r;
	logic [7:0] osh_r;
	logic [2:0] ocnt_r;
	logic [6:0] boff_r;
	logic [7:0] cmd_r;
	logic active_r;
	logic refused_r;

	// Two flops on every pin; only the second stage feeds logic
	always_ff @(posedge clk_i or posedge rst_i) begin
		if (rst_i) begin
			sync1_r <= `SLT_SYNC_RST;
			sync2_r <= `SLT_SYNC_RST;
			sck_d_r <= 1'b0;
		end else begin
			sync1_r <= {lnk.sck, lnk.cs_n, lnk.io};
			sync2_r <= sync1_r;
			sck_d_r <= sync2_r[5];
		end
	end

	assign sck_rise = sync2_r[5] & ~sck_d_r;
	assign sck_fall = ~sync2_r[5] & sck_d_r;
	assign cs_n = sync2_r[4];
	assign io_in = sync2_r[3:0];

	// Opcode decode against the row the latency code selects
	logic [7:0] op_w;
	slt_pkg::slt_fam_t fam_w;
	logic [7:0] mode_w;
	logic [7:0] dummy_w;
	logic unsup_w;
	logic [31:0] addr_w;
	always_comb begin
		op_w = {op_sh_r, io_in[0]};
		fam_w = slt_pkg::slt_fam_of(op_w);
		mode_w = slt_pkg::slt_mode_of(fam_w, slt_pkg::slt_row_of(latency_code_i, SCK_MHZ));
		dummy_w = slt_pkg::slt_dummy_of(fam_w, slt_pkg::slt_row_of(latency_code_i, SCK_MHZ));
		unsup_w = (fam_w == slt_pkg::SLT_FAM_NONE) || (mode_w == `SLT_NOSUP) ||
			(dummy_w == `SLT_NOSUP);
		if (alanes_r == `SLT_LANES4) begin
			addr_w = {addr_r[27:0], io_in};
		end else if (alanes_r == `SLT_LANES2) begin
			addr_w = {addr_r[29:0], io_in[1:0]};
		end else begin
			addr_w = {addr_r[30:0], io_in[0]};
		end
	end

	// Command sequencer on SCK rising edges; select high aborts anything
	always_ff @(posedge clk_i or posedge rst_i) begin
		if (rst_i) begin
			ph_r <= slt_pkg::SLT_PH_IDLE;
			fam_r <= slt_pkg::SLT_FAM_NONE;
			cnt_r <= 8'h00;
			op_sh_r <= 7'h00;
			addr_r <= 32'h0000_0000;
			alen_r <= `SLT_A3_BITS;
			alanes_r <= `SLT_LANES1;
			dlanes_r <= `SLT_LANES1;
			mode_r <= 8'h00;
			dummy_r <= 8'h00;
			cmd_r <= 8'h00;
			refused_r <= 1'b0;
		end else begin
			refused_r <= 1'b0;
			if (cs_n) begin
				ph_r <= slt_pkg::SLT_PH_IDLE;
				cnt_r <= 8'h00;
				addr_r <= 32'h0000_0000; // 3-byte forms must not inherit old high bits
			end else if (sck_rise) begin
				case (ph_r)
					slt_pkg::SLT_PH_IDLE, slt_pkg::SLT_PH_OPC: begin
						op_sh_r <= op_w[6:0];
						if (cnt_r == `SLT_OP_BITS - 8'h01) begin
							cnt_r <= 8'h00;
							cmd_r <= op_w;
							if (unsup_w) begin
								ph_r <= slt_pkg::SLT_PH_IGN;
								refused_r <= 1'b1;
							end else begin
								ph_r <= slt_pkg::SLT_PH_ADDR;
								fam_r <= fam_w;
								alen_r <= slt_pkg::slt_is_a4(op_w) ? `SLT_A4_BITS : `SLT_A3_BITS;
								alanes_r <= slt_pkg::slt_addr_lanes(fam_w);
								dlanes_r <= slt_pkg::slt_data_lanes(fam_w);
								mode_r <= mode_w;
								dummy_r <= dummy_w;
							end
						end else begin
							cnt_r <= cnt_r + 8'h01;
							ph_r <= slt_pkg::SLT_PH_OPC;
						end
					end
					slt_pkg::SLT_PH_ADDR: begin
						addr_r <= addr_w;
						if (cnt_r + 8'(alanes_r) == alen_r) begin
							cnt_r <= 8'h00;
							ph_r <= slt_pkg::slt_after_addr(mode_r, dummy_r);
						end else begin
							cnt_r <= cnt_r + 8'(alanes_r);
						end
					end
					// Mode bits are sampled and dropped: no continuous read
					slt_pkg::SLT_PH_MODE: begin
						if (cnt_r + 8'h01 == mode_r) begin
							cnt_r <= 8'h00;
							ph_r <= (dummy_r != 8'h00) ? slt_pkg::SLT_PH_DUMMY : slt_pkg::SLT_PH_DATA;
						end else begin
							cnt_r <= cnt_r + 8'h01;
						end
					end
					slt_pkg::SLT_PH_DUMMY: begin
						if (cnt_r + 8'h01 == dummy_r) begin
							cnt_r <= 8'h00;
							ph_r <= slt_pkg::SLT_PH_DATA;
						end else begin
							cnt_r <= cnt_r + 8'h01;
						end
					end
					default: begin
						ph_r <= ph_r;
					end
				endcase
			end
		end
	end

	// Data driver on SCK falling edges, lanes released on select high
	logic [7:0] cur_w;
	always_comb begin
		cur_w = (ocnt_r == 3'h0) ? slt_pkg::slt_param_byte(addr_r + 32'(boff_r)) : osh_r;
	end

	always_ff @(posedge clk_i or posedge rst_i) begin
		if (rst_i) begin
			io_o_r <= 4'h0;
			io_oe_n_r <= `SLT_OE_OFF;
			osh_r <= 8'h00;
			ocnt_r <= 3'h0;
			boff_r <= 7'h00;
		end else if (cs_n) begin
			io_oe_n_r <= `SLT_OE_OFF;
			ocnt_r <= 3'h0;
			boff_r <= 7'h00;
		end else if (sck_fall && ph_r == slt_pkg::SLT_PH_DATA) begin
			osh_r <= 8'(cur_w << dlanes_r);
			ocnt_r <= 3'(ocnt_r + dlanes_r);
			if (ocnt_r == 3'h0) begin
				boff_r <= boff_r + 7'h01; // Wraps after 128 bytes; all read as FFh there
			end
			if (dlanes_r == `SLT_LANES4) begin
				io_o_r <= cur_w[7:4];
				io_oe_n_r <= `SLT_OE_X4;
			end else if (dlanes_r == `SLT_LANES2) begin
				io_o_r <= {2'h0, cur_w[7:6]};
				io_oe_n_r <= `SLT_OE_X2;
			end else begin
				io_o_r <= {2'h0, cur_w[7], 1'b0};
				io_oe_n_r <= `SLT_OE_X1_OUT;
			end
		end
	end

	// Status for the user side
	always_ff @(posedge clk_i or posedge rst_i) begin
		if (rst_i) begin
			active_r <= 1'b0;
		end else begin
			active_r <= ~cs_n && (ph_r == slt_pkg::SLT_PH_DATA);
		end
	end

	assign lnk.d_io_o = io_o_r;
	assign lnk.d_io_oe_n = io_oe_n_r;
	assign cmd_o = cmd_r;
	assign active_o = active_r;
	assign refused_o = refused_r;
endmodule
`default_nettype wire

// ==== slt_link_sva.sv ====
// Checker on the host-device link pins.
// Assumes it sits beside the link, with the host built for a half period of 6 clk.
`default_nettype none
module slt_link_sva (
	input wire logic clk_i,
	input wire logic rst_i,
	input wire logic sck,
	input wire logic cs_n,
	input wire logic [3:0] h_io_o,
	input wire logic [3:0] h_io_oe_n,
	input wire logic [3:0] d_io_o,
	input wire logic [3:0] d_io_oe_n
);
	timeunit 1ns;
	timeprecision 100ps;
	default clocking @(posedge clk_i); endclocking
	default disable iff (rst_i);
	// Half periods of the link clock
	sequence s_hi; sck [*6]; endsequence
	sequence s_lo; !sck [*6]; endsequence
	property p_idle; cs_n |-> !sck && h_io_oe_n == 4'hF; endproperty
	property p_hi; $rose(sck) |-> s_hi; endproperty
	property p_lo; $fell(sck) && !cs_n |-> s_lo; endproperty
	property p_start; $fell(cs_n) |-> (!sck && h_io_oe_n == 4'hE) [*6]; endproperty
	property p_excl; ((~h_io_oe_n) & (~d_io_oe_n)) == 4'h0; endproperty
	property p_rel; cs_n [*5] |-> d_io_oe_n == 4'hF; endproperty
	property p_hset; !cs_n && $changed(h_io_o & ~h_io_oe_n) |-> !sck; endproperty
	property p_dset; !cs_n && $changed(d_io_o & ~d_io_oe_n) |-> !sck; endproperty
	// Lanes change only while the clock is low, so the far end samples clean bits
	a_idle: assert property (p_idle) else $error("link active while deselected");
	a_hi: assert property (p_hi) else $error("link clock high phase too short");
	a_lo: assert property (p_lo) else $error("link clock low phase too short");
	a_start: assert property (p_start) else $error("opcode lane not driven at select");
	a_excl: assert property (p_excl) else $error("both ends drive one lane");
	a_rel: assert property (p_rel) else $error("device drives while deselected");
	a_hset: assert property (p_hset) else $error("host lane moved while clock high");
	a_dset: assert property (p_dset) else $error("device lane moved while clock high");
endmodule
`default_nettype wire

// ==== tb_slt_read_latency_table.sv ====
// Bench: host and device joined by the link, user side driven at random.
// Assumes the design files and slt_params.svh are compiled first.
`default_nettype none
module tb_slt_read_latency_table;
	timeunit 1ns;
	timeprecision 100ps;
	logic clk_i = 0, rst_i = 1, start = 0, busy, rv, done, refd, d_ref, act, seen = 0, dsk = 0;
	logic [7:0] op = 0, nb = 0, rd, dcmd;
	logic [31:0] addr = 0, np, rs = 32'h0000_4781;
	logic [1:0] lc = 0, dlc = 0;
	int n_fail = 0, n_compared = 0, nr = 0, ra = 0, n_dref = 0;
	logic [7:0] ops [12] = '{8'h03, 8'h13, 8'h0B, 8'h0C, 8'h3B, 8'h3C, 8'h6B, 8'h6C,
		8'hBB, 8'hBC, 8'hEB, 8'hEC};
	slt_link_if lnk ();
	slt_host #(.SCK_HALF(6)) i_slt_host (.clk_i(clk_i), .rst_i(rst_i), .lnk(lnk),
		.start_i(start), .opcode_i(op), .addr_i(addr), .nbytes_i(nb), .latency_code_i(lc),
		.busy_o(busy), .rdata_o(rd), .rvalid_o(rv), .done_o(done), .refused_o(refd),
		.next_param_o(np));
	slt_dev i_slt_dev (.clk_i(clk_i), .rst_i(rst_i), .lnk(lnk), .latency_code_i(dlc),
		.cmd_o(dcmd), .active_o(act), .refused_o(d_ref));
	slt_link_sva i_slt_link_sva (.clk_i(clk_i), .rst_i(rst_i), .sck(lnk.sck),
		.cs_n(lnk.cs_n), .h_io_o(lnk.h_io_o), .h_io_oe_n(lnk.h_io_oe_n),
		.d_io_o(lnk.d_io_o), .d_io_oe_n(lnk.d_io_oe_n));
	// Mode and dummy counts per family and row, row 1 being 50 MHz
	function automatic logic [15:0] lat(input int f, input int r);
		if ((f == 0 && r > 1) || (r == 5 && f != 1)) return 16'hFFFF;
		case (f)
			4: return r < 3 ? 16'h0004 : {12'h000, 4'(r + 2)};
			5: return r == 1 ? 16'h0201 : r == 4 ? 16'h0205 : 16'h0204;
			default: return r == 1 ? 16'h0000 : 16'h0008;
		endcase
	endfunction
	// Expected parameter byte at relative offset o
	function automatic logic [7:0] expb(input int o);
		int r, c;
		logic [15:0] md;
		r = (o - 4) / 14;
		c = (o - 4) % 14;
		md = lat(c / 2 - 1, r);
		if (o < 4) return o == 0 ? 8'h90 : o == 1 ? 8'h56 : o == 2 ? 8'h06 : 8'h0E;
		if (o >= 88) return 8'hFF;
		if (r == 0) return c == 0 ? 8'h46 : c == 1 ? 8'h43 : ops[c - 2];
		if (c == 0) return r == 1 ? 8'h32 : r == 2 ? 8'h50 : r == 3 ? 8'h5A : r == 4 ? 8'h68 : 8'h85;
		if (c == 1) return r == 1 ? 8'h03 : r < 5 ? 8'(r - 2) : 8'h02;
		return c[0] ? md[7:0] : md[15:8];
	endfunction
	function automatic logic [31:0] lfsr(input logic [31:0] s);
		return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
	endfunction
	task automatic chk(input logic [31:0] got, input logic [31:0] exp);
		n_compared++;
		if (got !== exp) begin
			n_fail++;
			$display("[ERR] %0t got %h exp %h", $time, got, exp);
		end
	endtask
	task automatic end_of_test();
		$display("compared %0d failed %0d", n_compared, n_fail);
		if (n_fail == 0 && n_compared > 0) $display("Test passed");
		else $display("Test failed");
		$finish;
	endtask
	// Clock rises since select, frozen when the device first drives
	always @(negedge lnk.cs_n) begin
		nr = 0;
		seen = 0;
	end
	always @(posedge lnk.sck) nr = nr + 1;
	// Device refusals seen, each pulse once
	always @(posedge clk_i) if (d_ref === 1'b1) n_dref++;
	always @(posedge clk_i) if (!seen && !lnk.cs_n && lnk.d_io_oe_n !== 4'hF) begin
		seen = 1;
		ra = nr;
	end
	// One read; index 12 stands for an unknown opcode
	task automatic xfer(input int i, input logic [31:0] a, input logic [7:0] n,
		input logic [1:0] c);
		int f, k, t, e;
		logic [15:0] md;
		logic rf;
		f = i < 12 ? i / 2 : 7;
		md = lat(f, ((c + 1) & 3) + 1);
		rf = f == 7 || n == 0 || md == 16'hFFFF;
		lc = c;
		if (!dsk) begin
			dlc = c;
		end
		op = i < 12 ? ops[i] : 8'h5A;
		addr = a;
		nb = n;
		start = 1;
		@(posedge clk_i) #1 start = 0;
		k = 0;
		for (t = 0; t < 20000 && done !== 1'b1 && refd !== 1'b1; t++) begin
			if (rv === 1'b1) begin
				chk(rd, dsk ? 8'hFF : expb(a[6:0] + k));
				chk({busy, act}, {1'b1, !dsk});
				k++;
			end
			@(posedge clk_i) #1;
		end
		chk({done | refd, refd}, {1'b1, rf});
		if (!rf) begin
			chk(k, n);
			e = 8 + (i % 2 ? 32 : 24) / (f == 4 ? 2 : f == 5 ? 4 : 1) + md[15:8] + md[7:0];
			if (!dsk) begin
				chk(ra, e);
			end
			chk(dcmd, op);
		end
		@(posedge clk_i) #1;
	endtask
	initial forever #2 clk_i = ~clk_i;
	// Watchdog well past the expected run
	initial begin
		#300_000;
		n_fail++;
		end_of_test();
	end
	initial begin
		repeat (10) @(posedge clk_i);
		#1 rst_i = 0;
		xfer(0, 32'h0000_0000, 8'h02, 2'h3);
		chk(np, 32'h0000_0058);
		xfer(12, 32'h0000_0004, 8'h01, 2'h3);
		xfer(1, 32'h0000_0004, 8'h00, 2'h3);
		xfer(2, 32'h0000_0054, 8'h04, 2'h2);
		// Device at a faster code refuses; host then reads idle-high lanes
		dsk = 1;
		dlc = 2'h0;
		xfer(0, 32'h0000_0008, 8'h01, 2'h3);
		chk(n_dref, 1);
		dsk = 0;
		// Every opcode at every code, random offsets and lengths
		for (int c = 0; c < 4; c++) begin
			for (int i = 0; i < 12; i++) begin
				rs = lfsr(rs);
				xfer(i, {25'h0, rs[6:0] % 7'h55}, 8'(rs[9:8] + 1), 2'(c));
			end
		end
		chk(n_dref, 1);
		end_of_test();
	end
endmodule
`default_nettype wire
